// ---- logic/ppdh_top.sv ----
// Purpose: Pin-controlled power-down hold around a small register array.
// Assumes: One clock; all pins other than srst arrive asynchronously and are synchronised.
// Notes:   Power-down freezes state; wake-up is bounded by a cycle counter.
`include "ppdh_cfg.svh"

// Notes on behaviour
// - With the feature built in, a high pin means power-down, low means run.
// - On entry every data register and data output value is captured and held; the status flags change.
// - An output in high impedance at entry stays so until power-down ends.
// - While down, all inputs other than the power-down pin and srst are ignored.
// - While down, the two-way pin hold latches keep their last levels; input pins have none.
// - The feature is a build-time parameter, not switchable at run time.
// - With the feature used, the power-down pin never feeds the logic as data.
// - After the pin falls, inputs count and outputs are valid within 1 us.
module ppdh_top
	import ppdh_pkg::*;
#(
	parameter logic PD_ENABLE = `PPDH_PD_ENABLE,
	parameter int   DATA_W    = `PPDH_DATA_W
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              srst,
	// Power-down pin, also a plain input when the feature is absent
	input  wire logic              power_down_pin,
	// User logic inputs
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic              load_en,
	input  wire logic              out_en,
	// Two-way pins
	input  wire logic [DATA_W-1:0] bidir_i,
	output logic      [DATA_W-1:0] bidir_o,
	output logic                   bidir_oe,
	// Outputs
	output logic      [DATA_W-1:0] data_out,
	output logic      [DATA_W-1:0] comb_out,
	output logic                   pd_active,
	output logic                   ready
);
	// Refuse builds that the load mask or the settle counter cannot serve.
	if (DATA_W < 2 || DATA_W > 64) begin : g_bad_width
		$error("ppdh_top: DATA_W out of range");
	end
	if (`PPDH_RESUME_CYC < 1 ||
			`PPDH_WAKE_CYC < `PPDH_RESUME_CYC) begin : g_bad_wake
		$error("ppdh_top: wake budget too short");
	end
	if (`PPDH_RESUME_CYC >= (1 << `PPDH_CNT_W)) begin : g_bad_cnt
		$error("ppdh_top: settle count does not fit the counter");
	end

	// Running is decoded for the input gate and for both status flags.
	function automatic logic is_run(input ppdh_state_t s);
		return s == PPDH_RUN;
	endfunction

	localparam logic [`PPDH_CNT_W-1:0] RESUME_CYC =
		`PPDH_CNT_W'(`PPDH_RESUME_CYC);

	logic [DATA_W-1:0] data_s;
	logic [DATA_W-1:0] bidir_s;
	logic              load_s;
	logic              oe_s;
	logic              pd_s;

	ppdh_sync #(.W(2 * DATA_W + 2)) u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.d       ({data_in, bidir_i, load_en, out_en}),
		.q       ({data_s, bidir_s, load_s, oe_s})
	);

	// The pin has a synchroniser of its own; it joins the data only when the feature is absent.
	ppdh_sync #(.W(1)) u_pin_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.d       (power_down_pin),
		.q       (pd_s)
	);

	// The pin only counts as power-down control when built in.
	logic pd_req;
	assign pd_req = PD_ENABLE & pd_s;

	// Without the feature the pin is an ordinary user input.
	logic pin_as_data;
	assign pin_as_data = PD_ENABLE ? 1'h0 : pd_s;

	ppdh_state_t                state_reg;
	ppdh_state_t                state_next;
	logic [`PPDH_CNT_W-1:0]     cnt_reg;
	logic [`PPDH_CNT_W-1:0]     cnt_next;
	logic [DATA_W-1:0]          core_reg;
	logic [DATA_W-1:0]          core_next;
	logic [DATA_W-1:0]          keep_reg;
	logic [DATA_W-1:0]          keep_next;
	logic [DATA_W-1:0]          dout_next;
	logic [DATA_W-1:0]          comb_next;
	logic [DATA_W-1:0]          bo_next;
	logic                       oe_next;
	logic                       pd_active_next;
	logic                       ready_next;
	logic                       run;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			PPDH_RUN: begin
				if (pd_req)
					state_next = PPDH_DOWN;
			end
			PPDH_DOWN: begin
				if (!pd_req) begin
					state_next = PPDH_WAKE;
					cnt_next = '0;
				end
			end
			PPDH_WAKE: begin
				// Short settle well inside the wake budget.
				if (pd_req)
					state_next = PPDH_DOWN;
				else if (cnt_reg == RESUME_CYC - 1'h1)
					state_next = PPDH_RUN;
				else
					cnt_next = cnt_reg + 1'h1;
			end
			default: begin
				// An unused code falls back to run with the counter cleared.
				state_next = PPDH_RUN;
				cnt_next = '0;
			end
		endcase
	end

	assign run = is_run(state_reg) && !pd_req;

	// Pin hold latches keep the last sampled levels while down.
	always_comb begin
		keep_next = keep_reg;
		if (run)
			keep_next = bidir_s;
	end

	always_comb begin
		core_next = core_reg;
		if (run && load_s)
			core_next = data_s ^ keep_next ^ {{(DATA_W-1){1'h0}}, pin_as_data};
	end

	// Outputs update only while running; otherwise they hold, including Z.
	always_comb begin
		dout_next = data_out;
		comb_next = comb_out;
		bo_next = bidir_o;
		oe_next = bidir_oe;
		// Frozen copies cover both valid data and high impedance.
		if (run) begin
			dout_next = core_next;
			comb_next = core_next & keep_next;
			bo_next = core_next;
			oe_next = oe_s;
		end
	end

	// Both flags follow the state of the next edge, so they never lag it.
	always_comb begin
		pd_active_next = !is_run(state_next);
		ready_next = is_run(state_next);
	end

	// Power state registers.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= PPDH_RUN;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Hold latch register; nothing reloads it on wake.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			keep_reg <= '0;
		end else begin
			keep_reg <= keep_next;
		end
	end

	// Core register; nothing reloads it on wake either.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			core_reg <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	// Output registers, so every pin comes straight from a flip-flop.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			data_out <= '0;
			comb_out <= '0;
			bidir_o <= '0;
			bidir_oe <= 1'h0;
		end else begin
			data_out <= dout_next;
			comb_out <= comb_next;
			bidir_o <= bo_next;
			bidir_oe <= oe_next;
		end
	end

	// Status flag registers.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pd_active <= 1'h0;
			ready <= 1'h1;
		end else begin
			pd_active <= pd_active_next;
			ready <= ready_next;
		end
	end
endmodule

// ---- logic/ppdh_cfg.svh ----
// Purpose: Constants for the pin power-down hold block.
// Assumes: 50 MHz system clock.
// Notes:   Times are kept in their own units and converted to cycles here.
`ifndef PPDH_CFG_SVH
`define PPDH_CFG_SVH
`define PPDH_CLK_PERIOD_PS  20000
`define PPDH_SETUP_NS       15
`define PPDH_SETUP_CYC      ((`PPDH_SETUP_NS * 1000 + \
	`PPDH_CLK_PERIOD_PS - 1) / `PPDH_CLK_PERIOD_PS)
`define PPDH_RELEASE_NS     25
`define PPDH_WAKE_US        1
`define PPDH_WAKE_CYC       ((`PPDH_WAKE_US * 1000000) / `PPDH_CLK_PERIOD_PS)
`define PPDH_RESUME_CYC     4
`define PPDH_PD_ENABLE      1'h1
`define PPDH_DATA_W         8
`define PPDH_CNT_W          10
`endif

// ---- logic/ppdh_pkg.sv ----
// Purpose: Types for the pin power-down hold block.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds the power state enumeration.
package ppdh_pkg;
	typedef enum logic [1:0] {
		PPDH_RUN,
		PPDH_DOWN,
		PPDH_WAKE
	} ppdh_state_t;
endpackage

// ---- logic/ppdh_sync.sv ----
// Purpose: Two-stage synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   The first stage is read only by the second stage.
module ppdh_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         srst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end
endmodule

// ---- sim/ppdh_top_asserts.sv ----
// Purpose: Port checks for the power-down hold block.
// Assumes: Pins pass two synchroniser stages first.
// Notes:   Wake bound leaves slack over the 4-cycle settle.
module ppdh_chk #(parameter int DATA_W = 8) (
	input wire logic              clk_sys,
	input wire logic              srst,
	input wire logic              power_down_pin,
	input wire logic              bidir_oe,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic [DATA_W-1:0] comb_out,
	input wire logic              pd_active,
	input wire logic              ready);
	timeunit 1ns / 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	pd_enter_a: assert property (
		power_down_pin [*4] |=> pd_active) else $error("no entry");
	entry_cause_a: assert property (
		$rose(pd_active) |-> $past(power_down_pin, 3)) else $error("no cause");
	data_hold_a: assert property (
		pd_active ##1 pd_active |-> $stable(data_out)) else $error("moved");
	latch_hold_a: assert property (
		$past(pd_active) && pd_active |-> $stable(comb_out)) else $error("lost");
	hiz_hold_a: assert property (
		pd_active && !bidir_oe |=> !bidir_oe || !pd_active) else $error("oe");
	oe_freeze_a: assert property (
		pd_active ##1 pd_active |-> $stable(bidir_oe)) else $error("oe moved");
	wake_bound_a: assert property (
		!power_down_pin [*8] |=> ready) else $error("slow wake");
	resume_keep_a: assert property (
		$fell(pd_active) |-> $stable(data_out)) else $error("reinit");
endmodule
bind ppdh_top ppdh_chk #(.DATA_W(DATA_W)) chk_u (
	.clk_sys        (clk_sys),
	.srst           (srst),
	.power_down_pin (power_down_pin),
	.bidir_oe       (bidir_oe),
	.data_out       (data_out),
	.comb_out       (comb_out),
	.pd_active      (pd_active),
	.ready          (ready)
);

// ---- sim/ppdh_sys_model.sv ----
// Purpose: Outside logic that owns the power-down pin.
// Assumes: Requests change 1 ns after a clock edge.
// Notes:   The pin lags its request a cycle, so inputs stood 20 ns.
module ppdh_sys_model (
	input  wire logic       clk_sys,
	input  wire logic       want_pd,
	output logic            power_down_pin = 1'h0,
	output logic            churn,
	output logic      [7:0] junk = 8'h00);
	timeunit 1ns / 1ns;
	logic [1:0] up_cnt = 2'h0;
	always @(posedge clk_sys) begin
		power_down_pin <= #1 want_pd;
		up_cnt <= #1 power_down_pin ? up_cnt + {1'h0, ~&up_cnt} : 2'h0;
		junk <= #1 ~junk ^ 8'h3C;
	end
	assign churn = &up_cnt;
endmodule

// ---- sim/ppdh_tb.sv ----
// Purpose: Self-checking bench for the power-down hold block.
// Assumes: Default build with the feature present, 8-bit data.
// Notes:   Outside pins churn while down to prove they are blocked.
module pin_power_down_hold_tb_top;
	timeunit 1ns / 1ns;
	logic clk_sys = 1'h0, srst = 1'h1, want_pd = 1'h0, pd_active, ready;
	logic ld_req = 1'h0, oe_req = 1'h0, power_down_pin, load_en, out_en;
	logic bidir_oe, churn;
	logic [7:0] d_req = 8'h00, junk, data_in, bidir_i, bidir_o, comb_out;
	logic [7:0] data_out;
	int fail_count = 0, tests_run = 0;
	assign data_in = churn ? junk : d_req;
	assign load_en = churn ? junk[0] : ld_req;
	assign out_en = churn ? junk[1] : oe_req;
	assign bidir_i = bidir_oe ? bidir_o : churn ? junk : 8'hFF;
	ppdh_sys_model sys_u (
		.clk_sys        (clk_sys),
		.want_pd        (want_pd),
		.power_down_pin (power_down_pin),
		.churn          (churn),
		.junk           (junk)
	);
	ppdh_top dut_u (
		.clk_sys        (clk_sys),
		.srst           (srst),
		.power_down_pin (power_down_pin),
		.data_in        (data_in),
		.load_en        (load_en),
		.out_en         (out_en),
		.bidir_i        (bidir_i),
		.bidir_o        (bidir_o),
		.bidir_oe       (bidir_oe),
		.data_out       (data_out),
		.comb_out       (comb_out),
		.pd_active      (pd_active),
		.ready          (ready)
	);
	initial forever #10 clk_sys = ~clk_sys;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys) #1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic pd_hold(input logic [7:0] v, input logic oe);
		tick(6);
		d_req = v;
		ld_req = 1'h1;
		oe_req = oe;
		tick(1);
		ld_req = 1'h0;
		tick(5);
		want_pd = 1'h1;
		tick(12);
		chk({7'h00, pd_active}, 8'h01);
		chk(data_out, ~v);
		chk(bidir_o, ~v);
		chk({7'h00, bidir_oe}, {7'h00, oe});
		want_pd = 1'h0;
		tick(10);
		chk({7'h00, ready}, 8'h01);
		chk(comb_out, ~v);
		$display("pd_hold done");
	endtask
	initial begin
		tick(3);
		srst = 1'h0;
		pd_hold(8'hA5, 1'h0);
		pd_hold(8'h5A, 1'h1);
		tally_and_finish();
	end
	initial begin
		#3000; // Twice the expected run, so a stuck wait cannot hang.
		fail_count++;
		tally_and_finish();
	end
endmodule
